// ### rtl/lacsr_regs.sv
// Control and status register bank of the embedded logic analyzer.
// Contract
// (RULE_01) Run bit 0 stops the analyzer for programming; 1 enables capture and triggering.
// (RULE_02) Software avoids trace memory and integration registers while running.
// (RULE_03) While running, trigger, timestamp and pre-trigger registers are read only.
// (RULE_04) Run control and current state registers stay accessible in any run state.
// (RULE_05) Software programs timestamp control first and sets run last.
// (RULE_06) Software does not write timestamp or pre-trigger registers while running.
// (RULE_07) Timestamp enable bit 16; interval bits 15:12 pick the toggling counter bit.
// (RULE_08) A 16-bit trace counter runs freely on the analyzer clock.
// (RULE_09) A pending timestamp is written only in a cycle without trace capture.
// (RULE_10) Two timestamps never go to consecutive trace memory locations.
// (RULE_11) Interval zero writes a timestamp whenever trace turns off.
// (RULE_12) Clearing run writes a timestamp if the last write held payload.
// (RULE_13) Bits 7:4 and 3:0 select counter bits for header bits 1 and 0.
// (RULE_14) Alternate trace select keeps only bit 4 with five states; others zero.
// (RULE_15) Pre-trigger action drives outputs from run set until first trigger.
// (RULE_16) Action layout: outputs 7:4, trace 3, clock halt 2, cross triggers 1:0.
// (RULE_17) Reading current state latches counter and action snapshots together.
// (RULE_18) Bit 31 of current state reads 1 once the analyzer has halted.
// (RULE_19) Halted flag sets on final loop count or on zero successor taken.
// (RULE_20) Current state field is one-hot over the state count; rest reserved.
// (RULE_21) Current state and snapshot registers may be read in any run state.
// (RULE_22) While halted, the state field holds the state at halting.
// (RULE_23) Run clears itself when non-invasive debug authentication is withdrawn.
// (RULE_24) Software reads the captured tag only when stopped and capture exists.
// (RULE_25) Reserved and unlisted bits read zero and ignore writes.
`timescale 1ns/100ps
module lacsr_regs (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic noninvasive_auth,
  input wire logic [4:0] engine_state,
  input wire logic state_advance,
  input wire logic loop_final_count,
  input wire logic zero_successor_taken,
  input wire logic first_trigger_met,
  input wire logic [7:0] engine_action,
  input wire logic [31:0] engine_counter,
  input wire logic capture_active,
  input wire logic [9:0] captured_tag_in,
  output logic run,
  output logic halted_flag,
  output logic [3:0] general_outputs,
  output logic trace_enable,
  output logic clock_halt_out,
  output logic [1:0] cross_trigger_out,
  output logic independent_trace_enable,
  output logic [1:0] header_counter_bits,
  output logic [15:0] trace_counter,
  output logic timestamp_write
);
  logic run_r;
  logic [16:0] tsctl_r;
  logic indep_r;
  logic [7:0] ptact_r;
  logic halted_r;
  logic [4:0] state_r;
  logic in_pretrig_r;
  logic auth_s1_r;
  logic auth_s2_r;
  logic ts_pending_r;
  logic last_was_ts_r;
  logic last_was_data_r;
  logic trace_on_prev_r;
  logic [7:0] action_out_r;
  logic [7:0] action_out_nxt;
  logic wr;
  logic rd_state;
  logic wr_run;
  logic wr_tsctl;
  logic wr_alt;
  logic wr_ptact;
  logic cfg_writable;
  logic auth_lost;
  logic run_nxt;
  logic run_falling;
  logic ts_en;
  logic interval_toggle;
  logic trace_off_event;
  logic ts_request;
  logic ts_emit;
  logic [31:0] rdata_nxt;
  logic [31:0] state_word;
  logic [15:0] cnt;
  logic [31:0] counter_snap;
  logic [7:0] action_snap;
  logic hit_run;
  logic hit_tsctl;
  logic hit_alt;
  logic hit_ptact;
  logic hit_state;
  logic [31:0] run_word;
  logic [31:0] tsctl_word;
  logic [31:0] alt_word;
  logic [31:0] ptact_word;
  logic [31:0] action_word;
  logic [31:0] tag_word;

  assign hit_run = reg_addr == lacsr_pkg::off_run_control;
  assign hit_tsctl = reg_addr == lacsr_pkg::off_timestamp_control;
  assign hit_alt = reg_addr == lacsr_pkg::off_alternate_trace_select;
  assign hit_ptact = reg_addr == lacsr_pkg::off_pretrigger_action;
  assign hit_state = reg_addr == lacsr_pkg::off_current_trigger_state;
  assign wr = reg_sel & reg_write;
  // Only a read of the state register loads the snapshots, so other reads leave them alone.
  assign rd_state = reg_sel & ~reg_write & hit_state;
  // Run control is always writable; configuration only while stopped.
  assign wr_run = wr & hit_run; // [RULE_04]
  // A configuration write while running is dropped so that it cannot upset a capture in progress.
  assign cfg_writable = ~run_r; // [RULE_03]
  assign wr_tsctl = wr & cfg_writable & hit_tsctl; // [RULE_06]
  assign wr_alt = wr & cfg_writable & hit_alt;
  assign wr_ptact = wr & cfg_writable & hit_ptact; // [RULE_06]
  assign auth_lost = auth_s2_r == 1'b0;
  assign run_nxt = auth_lost ? 1'b0 : (wr_run ? reg_wdata[lacsr_pkg::run_bit] : run_r); // [RULE_23]
  assign run_falling = run_r & ~run_nxt;

  // Authentication comes from another domain, so it passes two flip-flops before it may stop the run.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      auth_s1_r <= 1'b0;
      auth_s2_r <= 1'b0;
    end
    else
    begin
      auth_s1_r <= noninvasive_auth;
      auth_s2_r <= auth_s1_r;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      run_r <= lacsr_pkg::run_control_reset[0];
    else
      run_r <= run_nxt; // [RULE_01]
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      tsctl_r <= lacsr_pkg::timestamp_control_reset;
    else if (wr_tsctl)
      tsctl_r <= {reg_wdata[16:12], 4'h0, reg_wdata[7:0]}; // [RULE_25]
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      indep_r <= 1'b0;
    else if (wr_alt)
      indep_r <= reg_wdata[lacsr_pkg::indep_trace_bit]; // [RULE_14]
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ptact_r <= lacsr_pkg::pretrigger_action_reset;
    else if (wr_ptact)
      ptact_r <= reg_wdata[7:0];
  end

  // Pre-trigger phase lasts from run set until the first trigger condition.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      in_pretrig_r <= 1'b0;
    else if (~run_r & run_nxt)
      in_pretrig_r <= 1'b1; // [RULE_15]
    else if (first_trigger_met | ~run_nxt)
      in_pretrig_r <= 1'b0;
  end

  // Outputs fall to zero in the same cycle as the run bit, so nothing is driven while stopped.
  assign action_out_nxt = ~run_nxt ? 8'h00 : ((~run_r | in_pretrig_r) & ~first_trigger_met) ? ptact_r : engine_action;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      action_out_r <= 8'h00;
    else
      action_out_r <= action_out_nxt; // [RULE_15]
  end
  assign general_outputs = action_out_r[7:4]; // [RULE_16]
  assign trace_enable = action_out_r[lacsr_pkg::act_trace_bit]; // [RULE_16]
  assign clock_halt_out = action_out_r[2]; // [RULE_16]
  assign cross_trigger_out = action_out_r[1:0]; // [RULE_16]

  // Halted flag and frozen state; a new run clears the flag.
  // Once halted the field stops following the engine, so software sees where the run ended.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      halted_r <= 1'b0;
      state_r <= lacsr_pkg::current_state_reset;
    end
    else if (~run_r & run_nxt)
    begin
      halted_r <= 1'b0;
      state_r <= engine_state;
    end
    else if (~halted_r)
    begin
      if (run_r & (loop_final_count | zero_successor_taken))
        halted_r <= 1'b1; // [RULE_19]
      if (state_advance | ~run_r)
        state_r <= engine_state; // [RULE_22]
    end
  end

  // Timestamp generation.
  assign ts_en = tsctl_r[lacsr_pkg::ts_enable_bit];
  lacsr_trace_counter u_counter (
    .clock(clock),
    .sys_rst(sys_rst),
    .interval_sel(tsctl_r[15:12]),
    .sel1(tsctl_r[7:4]),
    .sel0(tsctl_r[3:0]),
    .count(cnt),
    .bit_toggled(interval_toggle),
    .header_bits(header_counter_bits)
  );
  assign trace_off_event = trace_on_prev_r & ~action_out_r[lacsr_pkg::act_trace_bit];
  assign ts_request = ts_en & run_r & ((tsctl_r[15:12] != 4'h0) ? interval_toggle : trace_off_event); // [RULE_11]
  // Every request first waits in the pending flag, so it goes out one cycle later at the earliest.
  // Emit only when idle and never right after another timestamp.
  assign ts_emit = ts_pending_r & ~capture_active & ~last_was_ts_r; // [RULE_09] [RULE_10]
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ts_pending_r <= 1'b0;
      last_was_ts_r <= 1'b0;
      last_was_data_r <= 1'b0;
      trace_on_prev_r <= 1'b0;
    end
    else
    begin
      trace_on_prev_r <= action_out_r[lacsr_pkg::act_trace_bit];
      if (ts_request | (run_falling & last_was_data_r)) // [RULE_12]
        ts_pending_r <= 1'b1;
      else if (ts_emit)
        ts_pending_r <= 1'b0;
      if (capture_active)
      begin
        last_was_ts_r <= 1'b0;
        last_was_data_r <= 1'b1;
      end
      else if (ts_emit)
      begin
        last_was_ts_r <= 1'b1; // [RULE_10]
        last_was_data_r <= 1'b0;
      end
    end
  end
  assign timestamp_write = ts_emit;
  assign trace_counter = cnt;

  lacsr_snapshot u_snapshot (
    .clock(clock),
    .sys_rst(sys_rst),
    .capture(rd_state), // [RULE_17]
    .counter_in(engine_counter),
    .action_in(action_out_r),
    .counter_snap(counter_snap),
    .action_snap(action_snap)
  );

  assign state_word = {halted_r, 26'h0, state_r}; // [RULE_18] [RULE_20]
  assign run_word = {31'h0, run_r};
  assign tsctl_word = {15'h0, tsctl_r};
  assign alt_word = {27'h0, indep_r, 4'h0}; // [RULE_14]
  assign ptact_word = {24'h0, ptact_r};
  assign action_word = {24'h0, action_snap};
  assign tag_word = {22'h0, captured_tag_in};
  // The read mux is combinational, so the data stand in the same cycle as the select.
  always_comb
  begin
    rdata_nxt = lacsr_pkg::unmapped_read_value; // [RULE_25]
    unique case (reg_addr)
      lacsr_pkg::off_run_control: rdata_nxt = run_word;
      lacsr_pkg::off_timestamp_control: rdata_nxt = tsctl_word;
      lacsr_pkg::off_alternate_trace_select: rdata_nxt = alt_word; // [RULE_14]
      lacsr_pkg::off_pretrigger_action: rdata_nxt = ptact_word;
      lacsr_pkg::off_current_trigger_state: rdata_nxt = state_word; // [RULE_21]
      lacsr_pkg::off_counter_snapshot: rdata_nxt = counter_snap;
      lacsr_pkg::off_action_snapshot: rdata_nxt = action_word;
      lacsr_pkg::off_captured_transaction_tag: rdata_nxt = tag_word;
      default: rdata_nxt = lacsr_pkg::unmapped_read_value;
    endcase
  end
  assign reg_rdata = rdata_nxt;
  assign run = run_r;
  assign halted_flag = halted_r;
  assign independent_trace_enable = indep_r;
endmodule // lacsr_regs

// ### rtl/lacsr_pkg.sv
// Package with register offsets, field positions and reset values of the analyzer control bank.
package lacsr_pkg;
  localparam int unsigned state_count_param = 5;
  localparam logic [7:0] off_run_control = 8'h00;
  localparam logic [7:0] off_timestamp_control = 8'h04;
  localparam logic [7:0] off_alternate_trace_select = 8'h08;
  localparam logic [7:0] off_pretrigger_action = 8'h10;
  localparam logic [7:0] off_current_trigger_state = 8'h20;
  localparam logic [7:0] off_counter_snapshot = 8'h24;
  localparam logic [7:0] off_action_snapshot = 8'h28;
  localparam logic [7:0] off_captured_transaction_tag = 8'h2c;
  localparam int unsigned run_bit = 0;
  localparam int unsigned ts_enable_bit = 16;
  localparam int unsigned ts_interval_lsb = 12;
  localparam int unsigned hdr_sel1_lsb = 4;
  localparam int unsigned hdr_sel0_lsb = 0;
  localparam int unsigned indep_trace_bit = 4;
  localparam int unsigned halted_bit = 31;
  localparam int unsigned act_trace_bit = 3;
  localparam int unsigned tag_width = 10;
  localparam logic [31:0] run_control_reset = 32'h0000_0000;
  localparam logic [16:0] timestamp_control_reset = 17'h0_0000;
  localparam logic [7:0] pretrigger_action_reset = 8'h00;
  localparam logic [4:0] current_state_reset = 5'h01;
  localparam logic [31:0] unmapped_read_value = 32'h0000_0000;
endpackage

// ### rtl/lacsr_trace_counter.sv
// Free-running 16-bit trace counter with timestamp request and header bit selection.
`timescale 1ns/100ps
module lacsr_trace_counter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] interval_sel,
  input wire logic [3:0] sel1,
  input wire logic [3:0] sel0,
  output logic [15:0] count,
  output logic bit_toggled,
  output logic [1:0] header_bits
);
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] prev_r;
  assign count_nxt = count_r + 16'h0001;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_r <= 16'h0000;
      prev_r <= 16'h0000;
    end
    else
    begin
      count_r <= count_nxt; // [RULE_08]
      prev_r <= count_r;
    end
  end
  assign count = count_r;
  assign bit_toggled = count_r[interval_sel] ^ prev_r[interval_sel]; // [RULE_07]
  assign header_bits = {count_r[sel1], count_r[sel0]}; // [RULE_13]
endmodule // lacsr_trace_counter

// ### rtl/lacsr_snapshot.sv
// Snapshot holder for counter and action values, loaded when the state register is read.
`timescale 1ns/100ps
module lacsr_snapshot (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic capture,
  input wire logic [31:0] counter_in,
  input wire logic [7:0] action_in,
  output logic [31:0] counter_snap,
  output logic [7:0] action_snap
);
  logic [31:0] counter_snap_r;
  logic [7:0] action_snap_r;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      counter_snap_r <= 32'h0000_0000;
      action_snap_r <= 8'h00;
    end
    else if (capture)
    begin
      counter_snap_r <= counter_in; // [RULE_17]
      action_snap_r <= action_in; // [RULE_17]
    end
  end
  assign counter_snap = counter_snap_r;
  assign action_snap = action_snap_r;
endmodule // lacsr_snapshot

// ### testbench/lacsr_regs_monitor.sv
// Checker of the port behaviour of the analyzer register bank.
`timescale 1ns/100ps
module lacsr_regs_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic noninvasive_auth,
  input wire logic loop_final_count,
  input wire logic [31:0] engine_counter,
  input wire logic capture_active,
  input wire logic run,
  input wire logic halted_flag,
  input wire logic [3:0] general_outputs,
  input wire logic trace_enable,
  input wire logic clock_halt_out,
  input wire logic [1:0] cross_trigger_out,
  input wire logic [15:0] trace_counter,
  input wire logic timestamp_write
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire rd_on = reg_sel && !reg_write;
  wire mapped = reg_addr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c};
  wire [7:0] act = {general_outputs, trace_enable, clock_halt_out, cross_trigger_out};
  a_run_cause: assert property ($rose(run) |-> $past(reg_sel && reg_write && reg_addr == 8'h00 && reg_wdata[0]))
    else $error("run rose without a run write");
  a_auth_drop: assert property ((!noninvasive_auth) [*4] |-> !run)
    else $error("run kept after authentication loss");
  a_count_step: assert property (!$past(sys_rst) |-> trace_counter == 16'($past(trace_counter) + 16'h1))
    else $error("trace counter did not step by one");
  a_ts_idle: assert property (timestamp_write |-> !capture_active)
    else $error("timestamp written during capture");
  a_ts_apart: assert property (timestamp_write |=> !timestamp_write)
    else $error("timestamps back to back");
  a_halt_set: assert property (run && loop_final_count |=> halted_flag)
    else $error("halted flag not set on final count");
  a_state_word: assert property (rd_on && reg_addr == 8'h20 |->
    reg_rdata[31] == halted_flag && reg_rdata[30:5] == 26'h0 && $onehot(reg_rdata[4:0]))
    else $error("bad state word");
  a_snap_count: assert property (rd_on && reg_addr == 8'h20 ##2 rd_on && reg_addr == 8'h24 |->
    reg_rdata == $past(engine_counter, 2))
    else $error("counter snapshot mismatch");
  a_unmapped_zero: assert property (rd_on && !mapped |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_actions: assert property (!run && !$past(run) |-> act == 8'h0)
    else $error("action outputs active while stopped");
  cover property ($rose(run));
  cover property (timestamp_write);
  cover property ($rose(halted_flag));
endmodule // lacsr_regs_monitor

bind lacsr_regs lacsr_regs_monitor i_lacsr_regs_monitor (.*);

// ### testbench/lacsr_host.sv
// Register bus driver model of the debug host.
`timescale 1ns/100ps
module lacsr_host (
  input wire logic clock,
  input wire logic [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_sel,
  output logic reg_write,
  output logic [31:0] reg_wdata
);
  initial
  begin
    reg_addr = 8'h3c;
    reg_sel = 1'b0;
    reg_write = 1'b0;
    reg_wdata = 32'h0;
  end
  // Trace memory and integration registers are never touched; the tag is read only while stopped.
  // Idle address and data lines are inverted so stale values never look valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    #1;
    reg_sel = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = wd;
    @(posedge clock);
    rd = reg_rdata;
    #1;
    reg_sel = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~wd;
  endtask
endmodule // lacsr_host

// ### testbench/logic_analyzer_control_status_regs_test.sv
// Self-checking bench of the analyzer register bank.
`timescale 1ns/100ps
module logic_analyzer_control_status_regs_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic noninvasive_auth = 1'b1;
  logic [4:0] engine_state = 5'h01;
  logic state_advance = 1'b0;
  logic loop_final_count = 1'b0;
  logic zero_successor_taken = 1'b0;
  logic first_trigger_met = 1'b0;
  logic [7:0] engine_action = 8'h3c;
  logic [31:0] engine_counter = 32'h1234_5678;
  logic capture_active = 1'b0;
  logic [9:0] captured_tag_in = 10'h155;
  logic [7:0] reg_addr;
  logic reg_sel;
  logic reg_write;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic run;
  logic halted_flag;
  logic [3:0] general_outputs;
  logic trace_enable;
  logic clock_halt_out;
  logic [1:0] cross_trigger_out;
  logic independent_trace_enable;
  logic [1:0] header_counter_bits;
  logic [15:0] trace_counter;
  logic timestamp_write;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 clock = ~clock;
  lacsr_regs i_lacsr_regs (.*);
  lacsr_host i_lacsr_host (.*);
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_lacsr_host.xfer(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    i_lacsr_host.xfer(1'b1, a, v, d);
  endtask
  task automatic pulse_count(input int exp);
    int n;
    n = 0;
    repeat (64)
    begin
      @(negedge clock);
      n += (timestamp_write === 1'b0) ? 0 : 1;
    end
    chk(32'(n), 32'(exp));
  endtask
  task automatic t_reset;
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h10, 32'h0);
    rc(8'h20, 32'h1);
    rc(8'h30, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_prog;
    wr(8'h04, 32'hffff_ffff);
    rc(8'h04, 32'h0001_f0ff);
    wr(8'h08, 32'hffff_ffff);
    rc(8'h08, 32'h10);
    chk(32'(independent_trace_enable), 32'h1);
    wr(8'h10, 32'hffff_ff5a);
    rc(8'h10, 32'h5a);
    wr(8'h04, 32'h0001_2031);
    @(negedge clock);
    chk(32'(header_counter_bits), {30'h0, trace_counter[3], trace_counter[1]});
    $display("t_prog done");
  endtask
  task automatic t_run;
    wr(8'h00, 32'h1);
    @(negedge clock);
    chk(32'(run), 32'h1);
    chk({24'h0, general_outputs, trace_enable, clock_halt_out, cross_trigger_out}, 32'h5a);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h5a);
    rc(8'h00, 32'h1);
    pulse_count(0);
    @(posedge clock);
    #1;
    capture_active = 1'b1;
    pulse_count(0);
    @(posedge clock);
    #1;
    capture_active = 1'b0;
    pulse_count(1);
    @(posedge clock);
    #1;
    first_trigger_met = 1'b1;
    @(posedge clock);
    #1;
    first_trigger_met = 1'b0;
    @(negedge clock);
    chk({24'h0, general_outputs, trace_enable, clock_halt_out, cross_trigger_out}, 32'h3c);
    $display("t_run done");
  endtask
  task automatic t_snap;
    @(posedge clock);
    #1;
    engine_state = 5'h04;
    state_advance = 1'b1;
    @(posedge clock);
    #1;
    state_advance = 1'b0;
    rc(8'h20, 32'h4);
    engine_counter = 32'h0bad_0001;
    rc(8'h24, 32'h1234_5678);
    rc(8'h28, 32'h3c);
    $display("t_snap done");
  endtask
  task automatic t_halt;
    @(posedge clock);
    #1;
    zero_successor_taken = 1'b1;
    @(posedge clock);
    #1;
    zero_successor_taken = 1'b0;
    loop_final_count = 1'b1;
    engine_state = 5'h10;
    state_advance = 1'b1;
    @(posedge clock);
    #1;
    loop_final_count = 1'b0;
    state_advance = 1'b0;
    rc(8'h20, 32'h8000_0004);
    $display("t_halt done");
  endtask
  task automatic t_auth;
    @(posedge clock);
    #1;
    noninvasive_auth = 1'b0;
    repeat (4) @(posedge clock);
    rc(8'h00, 32'h0);
    rc(8'h2c, 32'h155);
    rc(8'h24, 32'h0bad_0001);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h0);
    $display("t_auth done");
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_reset;
    t_prog;
    t_run;
    t_snap;
    t_halt;
    t_auth;
    final_report;
  end
endmodule // logic_analyzer_control_status_regs_test
